//--- pvmr_pkg.sv
package pvmr_pkg;

   // ----------------------------------------------------------------
   // register numbers on the management interface
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_STATUS_CONTROL = 5'h10;
   localparam logic [4:0] REG_SPECIAL_TEST   = 5'h11;
   localparam logic [4:0] REG_FIXED_ADDRESS  = 5'h12;
   localparam logic [4:0] REG_FALSE_CARRIER  = 5'h13;
   localparam logic [4:0] REG_DISCONNECT     = 5'h14;
   localparam logic [4:0] REG_ERROR_FRAME    = 5'h15;
   localparam logic [4:0] REG_SYMBOL_ERROR   = 5'h16;
   localparam logic [4:0] REG_IEEE_RSV_FIRST = 5'h08;
   localparam logic [4:0] REG_IEEE_RSV_LAST  = 5'h0f;

   // ----------------------------------------------------------------
   // field positions of the status and control word
   // ----------------------------------------------------------------
   localparam int SC_DISCONNECT_EN = 13;
   localparam int SC_FLOW_CTRL_EN  = 12;
   localparam int SC_DESER_SYNC    = 11;
   localparam int SC_PD_100        = 10;
   localparam int SC_PD_10         = 9;
   localparam int SC_POLARITY      = 8;
   localparam int SC_SPEED_100     = 1;
   localparam int SC_FULL_DUPLEX   = 0;

   // ----------------------------------------------------------------
   // reset values, masks, fixed register value and count limit
   // ----------------------------------------------------------------
   localparam logic [15:0] SPECIAL_TEST_RESET = 16'h0000;
   localparam logic [15:0] SPECIAL_TEST_MASK  = 16'hfbff;
   localparam logic [15:0] FIXED_ADDRESS_VAL  = 16'h0001;
   localparam logic [1:0]  SC_CTRL_RESET      = 2'h0;
   localparam logic [1:0]  SC_PD_RESET        = 2'h3;
   localparam logic [15:0] COUNT_MAX          = 16'hffff;

   // ----------------------------------------------------------------
   // symbol error grouping
   // ----------------------------------------------------------------
   localparam logic [2:0] SYMBOLS_PER_COUNT = 3'h6;

endpackage : pvmr_pkg

//--- pvmr_regs.sv
`timescale 1ns/1ps

module pvmr_regs
   import pvmr_pkg::*;
(
   // clock and reset
   input  wire logic        CLK_I,
   input  wire logic        ARST_N_I,
   // management register access
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   input  wire logic [4:0]  REG_ADDR_I,
   input  wire logic [15:0] REG_WDATA_I,
   output logic      [15:0] REG_RDATA_O,
   output logic             REG_RVALID_O,
   // status from the phy sections
   input  wire logic        DESER_SYNC_I,
   input  wire logic        PD_100_I,
   input  wire logic        PD_10_I,
   input  wire logic        POLARITY_REV_I,
   input  wire logic        SPEED_100_I,
   input  wire logic        FULL_DUPLEX_I,
   // receive events
   input  wire logic        FALSE_CARRIER_I,
   input  wire logic        DISCONNECT_I,
   input  wire logic        RX_FRAME_ACTIVE_I,
   input  wire logic        RX_FRAME_ERROR_I,
   input  wire logic        SYMBOL_ERROR_I,
   // controls to the phy sections
   output logic             DISCONNECT_EN_O,
   output logic             FLOW_CTRL_EN_O,
   output logic             SCRAMBLER_BYPASS_O,
   output logic             CODER_BYPASS_O,
   output logic             FORCE_H_PATTERN_O,
   output logic             FORCE_34_PATTERN_O,
   output logic             FORCE_LINK_GOOD_O,
   output logic             TX_CRS_DISABLE_O,
   output logic             DYN_PD_DISABLE_O,
   output logic             AN_LOOPBACK_O,
   output logic             TX_TRISTATE_O,
   output logic             FILTER_BYPASS_O,
   output logic             AUTO_POL_DISABLE_O,
   output logic             SQUELCH_DISABLE_O,
   output logic             EXT_SQUELCH_O,
   output logic             LINK_INTEG_DISABLE_O,
   output logic             JABBER_DISABLE_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [1:0]  sc_ctrl;
      logic [1:0]  pd;
      logic [15:0] special;
      logic [15:0] false_carrier;
      logic [15:0] disconnect;
      logic [15:0] error_frame;
      logic [15:0] symbol_error;
      logic        frame_err_seen;
      logic [2:0]  sym_run;
      logic [15:0] rdata;
      logic        rvalid;
   } pvmr_state_t;

   pvmr_state_t s_q;
   pvmr_state_t s_d;

   // saturating count with read clear; a same-cycle event lands after the clear
   function automatic logic [15:0] pvmr_count(input logic [15:0] cur,
                                               input logic        clr,
                                               input logic        evt);
      logic [15:0] base;
      base = clr ? 16'h0000 : cur;
      if (evt && (base != COUNT_MAX))
         pvmr_count = base + 16'h0001;
      else
         pvmr_count = base;
   endfunction

   logic [15:0] status_word;
   logic        rd_fc;
   logic        rd_dc;
   logic        rd_ef;
   logic        rd_se;
   logic        frame_err_evt;
   logic        sym_evt;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;

      status_word                 = 16'h0000;
      status_word[SC_DISCONNECT_EN] = s_q.sc_ctrl[1];
      status_word[SC_FLOW_CTRL_EN]  = s_q.sc_ctrl[0];
      status_word[SC_DESER_SYNC]    = DESER_SYNC_I;
      status_word[SC_PD_100]        = s_q.pd[1];
      status_word[SC_PD_10]         = s_q.pd[0];
      status_word[SC_POLARITY]      = POLARITY_REV_I;
      status_word[SC_SPEED_100]     = SPEED_100_I;
      status_word[SC_FULL_DUPLEX]   = FULL_DUPLEX_I;

      // power-down state follows the sections once out of reset
      s_d.pd = {PD_100_I, PD_10_I};

      rd_fc = REG_RD_I && (REG_ADDR_I == REG_FALSE_CARRIER);
      rd_dc = REG_RD_I && (REG_ADDR_I == REG_DISCONNECT);
      rd_ef = REG_RD_I && (REG_ADDR_I == REG_ERROR_FRAME);
      rd_se = REG_RD_I && (REG_ADDR_I == REG_SYMBOL_ERROR);

      // one count per errored frame, taken when the error is first seen
      frame_err_evt = RX_FRAME_ACTIVE_I && RX_FRAME_ERROR_I && !s_q.frame_err_seen;
      if (!RX_FRAME_ACTIVE_I)
         s_d.frame_err_seen = 1'b0;
      else if (RX_FRAME_ERROR_I)
         s_d.frame_err_seen = 1'b1;

      // a run of bad symbols counts once at its start and once per six after
      sym_evt = SYMBOL_ERROR_I && RX_FRAME_ACTIVE_I && (s_q.sym_run == 3'h0);
      if (!SYMBOL_ERROR_I || !RX_FRAME_ACTIVE_I)
         s_d.sym_run = 3'h0;
      else if (s_q.sym_run == SYMBOLS_PER_COUNT - 3'h1)
         s_d.sym_run = 3'h0;
      else
         s_d.sym_run = s_q.sym_run + 3'h1;

      s_d.false_carrier = pvmr_count(s_q.false_carrier, rd_fc, FALSE_CARRIER_I);
      s_d.disconnect    = pvmr_count(s_q.disconnect, rd_dc, DISCONNECT_I);
      s_d.error_frame   = pvmr_count(s_q.error_frame, rd_ef, frame_err_evt);
      s_d.symbol_error  = pvmr_count(s_q.symbol_error, rd_se, sym_evt);

      // writes; reserved bits are dropped
      if (REG_WR_I)
      begin
         unique case (REG_ADDR_I)
            REG_STATUS_CONTROL:
               s_d.sc_ctrl = {REG_WDATA_I[SC_DISCONNECT_EN],
                              REG_WDATA_I[SC_FLOW_CTRL_EN]};
            REG_SPECIAL_TEST:
               s_d.special = REG_WDATA_I & SPECIAL_TEST_MASK;
            default:
               s_d.special = s_q.special;
         endcase
      end

      // reads return the value held before any clear
      s_d.rvalid = REG_RD_I;
      if (REG_RD_I)
      begin
         unique case (REG_ADDR_I)
            REG_STATUS_CONTROL: s_d.rdata = status_word;
            REG_SPECIAL_TEST:   s_d.rdata = s_q.special;
            REG_FIXED_ADDRESS:  s_d.rdata = FIXED_ADDRESS_VAL;
            REG_FALSE_CARRIER:  s_d.rdata = s_q.false_carrier;
            REG_DISCONNECT:     s_d.rdata = s_q.disconnect;
            REG_ERROR_FRAME:    s_d.rdata = s_q.error_frame;
            REG_SYMBOL_ERROR:   s_d.rdata = s_q.symbol_error;
            default:            s_d.rdata = 16'h0000;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge ARST_N_I)
   begin
      if (!ARST_N_I)
      begin
         s_q                <= '0;
         s_q.sc_ctrl        <= SC_CTRL_RESET;
         s_q.pd             <= SC_PD_RESET;
         s_q.special        <= SPECIAL_TEST_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign REG_RDATA_O          = s_q.rdata;
   assign REG_RVALID_O         = s_q.rvalid;
   assign DISCONNECT_EN_O      = s_q.sc_ctrl[1];
   assign FLOW_CTRL_EN_O       = s_q.sc_ctrl[0];
   assign SCRAMBLER_BYPASS_O   = s_q.special[15];
   assign CODER_BYPASS_O       = s_q.special[14];
   assign FORCE_H_PATTERN_O    = s_q.special[13];
   assign FORCE_34_PATTERN_O   = s_q.special[12];
   assign FORCE_LINK_GOOD_O    = s_q.special[11];
   assign TX_CRS_DISABLE_O     = s_q.special[9];
   assign DYN_PD_DISABLE_O     = s_q.special[8];
   assign AN_LOOPBACK_O        = s_q.special[7];
   assign TX_TRISTATE_O        = s_q.special[6];
   assign FILTER_BYPASS_O      = s_q.special[5];
   assign AUTO_POL_DISABLE_O   = s_q.special[4];
   assign SQUELCH_DISABLE_O    = s_q.special[3];
   assign EXT_SQUELCH_O        = s_q.special[2];
   assign LINK_INTEG_DISABLE_O = s_q.special[1];
   assign JABBER_DISABLE_O     = s_q.special[0];

endmodule // pvmr_regs

//--- pvmr_props.sv
`timescale 1ns/1ps
module pvmr_props
   import pvmr_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        ARST_N_I,
   input wire logic        REG_WR_I,
   input wire logic        REG_RD_I,
   input wire logic [4:0]  REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic [15:0] REG_RDATA_O,
   input wire logic        REG_RVALID_O,
   input wire logic        DESER_SYNC_I,
   input wire logic        POLARITY_REV_I,
   input wire logic        SPEED_100_I,
   input wire logic        FULL_DUPLEX_I,
   input wire logic        DISCONNECT_EN_O,
   input wire logic        FLOW_CTRL_EN_O,
   input wire logic        SCRAMBLER_BYPASS_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   read_answer_a: assert property (REG_RD_I ##1 !REG_RD_I |-> REG_RVALID_O ##1 $stable(REG_RDATA_O))
      else $error("read answer missing or data not held");
   fixed_addr_a: assert property (REG_RD_I && REG_ADDR_I == REG_FIXED_ADDRESS
      |=> REG_RDATA_O == FIXED_ADDRESS_VAL) else $error("address register value wrong");
   ieee_rsv_a: assert property (REG_RD_I && REG_ADDR_I inside {[5'h08:5'h0f]}
      |=> REG_RDATA_O == 16'h0000) else $error("reserved register reads nonzero");
   discon_wr_a: assert property (REG_WR_I && REG_ADDR_I == REG_STATUS_CONTROL
      |=> DISCONNECT_EN_O == $past(REG_WDATA_I[SC_DISCONNECT_EN])) else $error("disconnect bit");
   flow_wr_a: assert property (REG_WR_I && REG_ADDR_I == REG_STATUS_CONTROL
      |=> FLOW_CTRL_EN_O == $past(REG_WDATA_I[SC_FLOW_CTRL_EN])) else $error("flow bit");
   status_rd_a: assert property (REG_RD_I && REG_ADDR_I == REG_STATUS_CONTROL
      |=> {REG_RDATA_O[11], REG_RDATA_O[8], REG_RDATA_O[1:0]} == {$past(DESER_SYNC_I),
      $past(POLARITY_REV_I), $past(SPEED_100_I), $past(FULL_DUPLEX_I)}) else $error("status");
   scram_wr_a: assert property (REG_WR_I && REG_ADDR_I == REG_SPECIAL_TEST
      |=> SCRAMBLER_BYPASS_O == $past(REG_WDATA_I[15])) else $error("scrambler bit");
   scram_hold_a: assert property (!(REG_WR_I && REG_ADDR_I == REG_SPECIAL_TEST)
      |=> $stable(SCRAMBLER_BYPASS_O)) else $error("scrambler bit changed unwritten");
endmodule // pvmr_props

//--- pvmr_mgmt_model.sv
`timescale 1ns/1ps
module pvmr_mgmt_model
   import pvmr_pkg::*;
(
   input  wire logic        clk_i,
   output logic             wr_o,
   output logic             rd_o,
   output logic      [4:0]  addr_o,
   output logic      [15:0] wdata_o,
   input  wire logic [15:0] rdata_i,
   input  wire logic        rvalid_i
);
   initial
   begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      addr_o = 5'h00;
      wdata_o = 16'h0000;
   end
   // called just after a rising edge; wdata_o after a write and addr_o after a read get inverted values
   task automatic wr_reg(input logic [4:0] a, input logic [15:0] d, input logic [15:0] rsv);
      wr_o = 1'b1;
      addr_o = a;
      wdata_o = d & ~rsv;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
      wdata_o = ~wdata_o;
      // one idle edge, so a following call never re-raises a strobe in this time step
      @(posedge clk_i);
      #1;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [15:0] d, output logic v);
      rd_o = 1'b1;
      addr_o = a;
      @(posedge clk_i);
      #1 rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
      v = rvalid_i;
      // one idle edge, so a following call never re-raises a strobe in this time step
      @(posedge clk_i);
      #1;
   endtask
endmodule // pvmr_mgmt_model

//--- tb.sv
`timescale 1ns/1ps
module tb;
   import pvmr_pkg::*;
   logic        clk, arst_n, wr, rd, rvalid, rv;
   logic [4:0]  addr, evt;
   logic [15:0] wdata, rdata, d;
   logic [5:0]  sts;
   logic [14:0] ctl;
   logic [1:0]  ctl2;
   logic [15:0] pat [3] = '{16'hfbff, 16'h5a5a, 16'h0000};
   int          num_errors, checked;
   pvmr_mgmt_model pvmr_mgmt_model_inst (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(addr),
      .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
   pvmr_regs pvmr_regs_inst (.CLK_I(clk), .ARST_N_I(arst_n), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .DESER_SYNC_I(sts[5]), .PD_100_I(sts[4]), .PD_10_I(sts[3]), .POLARITY_REV_I(sts[2]),
      .SPEED_100_I(sts[1]), .FULL_DUPLEX_I(sts[0]), .FALSE_CARRIER_I(evt[0]),
      .DISCONNECT_I(evt[1]), .RX_FRAME_ACTIVE_I(evt[2]), .RX_FRAME_ERROR_I(evt[3]),
      .SYMBOL_ERROR_I(evt[4]), .DISCONNECT_EN_O(ctl2[1]), .FLOW_CTRL_EN_O(ctl2[0]),
      .SCRAMBLER_BYPASS_O(ctl[14]), .CODER_BYPASS_O(ctl[13]), .FORCE_H_PATTERN_O(ctl[12]),
      .FORCE_34_PATTERN_O(ctl[11]), .FORCE_LINK_GOOD_O(ctl[10]), .TX_CRS_DISABLE_O(ctl[9]),
      .DYN_PD_DISABLE_O(ctl[8]), .AN_LOOPBACK_O(ctl[7]), .TX_TRISTATE_O(ctl[6]),
      .FILTER_BYPASS_O(ctl[5]), .AUTO_POL_DISABLE_O(ctl[4]), .SQUELCH_DISABLE_O(ctl[3]),
      .EXT_SQUELCH_O(ctl[2]), .LINK_INTEG_DISABLE_O(ctl[1]), .JABBER_DISABLE_O(ctl[0]));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      pvmr_mgmt_model_inst.rd_reg(a, d, rv);
      check({15'h0000, rv}, 16'h0001);
      check(d, exp);
   endtask
   // holds the event lines for n sampled edges
   task automatic drive(input logic [4:0] v, input int n);
      evt = v;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic conclude();
      if (num_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (80000) @(posedge clk);
      num_errors++;
      conclude();
   end
   initial
   begin
      arst_n = 1'b0;
      sts = 6'b011000;
      evt = 5'h00;
      num_errors = 0;
      checked = 0;
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      rd_chk(REG_STATUS_CONTROL, 16'h0600);
      rd_chk(REG_SPECIAL_TEST, SPECIAL_TEST_RESET);
      for (int a = 19; a <= 22; a++) pvmr_mgmt_model_inst.rd_reg(a[4:0], d, rv);
      foreach (pat[i])
      begin
         pvmr_mgmt_model_inst.wr_reg(REG_SPECIAL_TEST, pat[i], ~SPECIAL_TEST_MASK);
         rd_chk(REG_SPECIAL_TEST, pat[i]);
         check({1'b0, ctl}, {1'b0, pat[i][15:11], pat[i][9:0]});
      end
      sts = 6'b101011;
      pvmr_mgmt_model_inst.wr_reg(REG_STATUS_CONTROL, 16'h2000, 16'hc0fc);
      rd_chk(REG_STATUS_CONTROL, 16'h2a03);
      check({14'h0000, ctl2}, 16'h0002);
      pvmr_mgmt_model_inst.wr_reg(REG_FIXED_ADDRESS, 16'h001e, 16'h0000);
      rd_chk(REG_FIXED_ADDRESS, FIXED_ADDRESS_VAL);
      for (int a = 8; a <= 15; a++) rd_chk(a[4:0], 16'h0000);
      drive(5'b00001, 3);
      rd_chk(REG_FALSE_CARRIER, 16'h0003);
      evt = 5'h00;
      rd_chk(REG_FALSE_CARRIER, 16'h0002);
      drive(5'b00010, 65537);
      drive(5'b00000, 1);
      rd_chk(REG_DISCONNECT, COUNT_MAX);
      rd_chk(REG_DISCONNECT, 16'h0000);
      repeat (2)
      begin
         drive(5'b00100, 2);
         drive(5'b01100, 3);
         drive(5'b00100, 2);
         drive(5'b00000, 2);
      end
      drive(5'b01000, 2);
      drive(5'b00000, 1);
      rd_chk(REG_ERROR_FRAME, 16'h0002);
      drive(5'b00100, 1);
      drive(5'b10100, 13);
      drive(5'b00100, 1);
      drive(5'b10100, 2);
      drive(5'b00000, 1);
      rd_chk(REG_SYMBOL_ERROR, 16'h0004);
      conclude();
   end
endmodule // tb
bind pvmr_regs pvmr_props pvmr_props_inst (.*);
